// ===== src/rtc_params.svh
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define RTC_I2C_ADDR 7'h51
`define RTC_REG_SEC 5'h00
`define RTC_REG_TOD_LAST 5'h06
`define RTC_REG_LAST 5'h10
`define RTC_HOUR_FMT_BIT 6
`define RTC_HOUR_MER_BIT 5
`define RTC_CENTURY_BIT 7
`define RTC_MASK_SEC 8'h7F
`define RTC_MASK_HOUR 8'h7F
`define RTC_MASK_DAY 8'h07
`define RTC_MASK_DATE 8'h3F
`define RTC_MASK_MONTH 8'h9F
`define RTC_MAX_SEC 8'h59
`define RTC_MAX_H24 6'h23
`define RTC_MAX_H12 5'h12
`define RTC_FLIP_H12 5'h11
`define RTC_MAX_DAY 3'h7
`define RTC_MAX_MONTH 5'h12
`define RTC_MAX_YEAR 8'h99
`define RTC_FEB 5'h02
`define RTC_DIM_28 8'h28
`define RTC_DIM_29 8'h29
`define RTC_DIM_30 8'h30
`define RTC_DIM_31 8'h31
`define RTC_TOD_RST 56'h00_01_01_01_00_00_00
`define RTC_MCLK_HZ 100000000
`define RTC_OSC_HZ 32768
`define RTC_SQW_HIGH_MS 500
`define RTC_RECOVERY_NS 250000
`define RTC_RECOVERY_CYC ((`RTC_RECOVERY_NS * (`RTC_MCLK_HZ / 1000000) + 999) / 1000)
`endif

// ===== src/rtc_pkg.sv
package rtc_pkg;
  typedef logic [6:0][7:0] rtc_tod_t;
  typedef enum logic [2:0] {
    rtc_idle, rtc_addr, rtc_addr_ack, rtc_wr, rtc_wr_ack, rtc_rd, rtc_rd_ack
  } rtc_i2c_st_e;
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    rtc_i2c_st_e st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic oe;
    logic first;
    logic start;
    logic wr_stb;
    logic rd_stb;
  } rtc_tgt_s;
  typedef struct packed {
    logic [1:0] pf_s;
    logic [1:0] bk_s;
    logic [1:0] en_s;
    logic [1:0] wv_s;
    logic [2:0] ack_s;
    logic [23:0] rec;
    logic access;
    logic backup;
    logic wave_oe;
    logic [16:0][7:0] mem;
    logic [4:0] ptr;
    logic snap_req;
    logic wr_req;
    logic [2:0] wr_idx;
    logic [7:0] wr_val;
  } rtc_core_s;
  typedef struct packed {
    logic [2:0] wr_s;
    logic [2:0] snp_s;
    rtc_tod_t tod;
    rtc_tod_t hold;
    logic [23:0] div;
    logic snap_ack;
    logic wave;
  } rtc_osc_s;
endpackage

// ===== src/rtc_ifs.sv
`timescale 1ns/1ns
interface rtc_bus_if;
  logic start;
  logic wr_stb;
  logic rd_stb;
  logic first;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic access_ok;
  modport tgt(output start, wr_stb, rd_stb, first, wr_data, input rd_data, access_ok);
  modport core(input start, wr_stb, rd_stb, first, wr_data, output rd_data, access_ok);
endinterface // rtc_bus_if

interface rtc_step_if;
  rtc_pkg::rtc_tod_t cur;
  rtc_pkg::rtc_tod_t nxt;
  modport calc(input cur, output nxt);
  modport user(output cur, input nxt);
endinterface // rtc_step_if

// ===== src/rtc_tod_step.sv
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_tod_step (
  rtc_step_if.calc tif // current time in, time one second later out
);
  function automatic logic [7:0] binc(input logic [7:0] v);
    binc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  always_comb begin
    logic [7:0] sec, mn, hr, dy, dt, mo, yr, dim;
    logic carry;
    logic pm;
    logic [4:0] h12;
    {yr, mo, dt, dy, hr, mn, sec} = tif.cur;
    carry = 1'b0;
    pm = hr[`RTC_HOUR_MER_BIT];
    h12 = hr[4:0];
    if (sec == `RTC_MAX_SEC) begin
      sec = 8'h00;
      carry = 1'b1;
    end else begin
      sec = binc(sec);
    end
    if (carry) begin
      if (mn == `RTC_MAX_SEC) begin
        mn = 8'h00;
      end else begin
        mn = binc(mn);
        carry = 1'b0;
      end
    end
    if (carry) begin
      carry = 1'b0;
      if (hr[`RTC_HOUR_FMT_BIT]) begin
        if (h12 == `RTC_MAX_H12) begin
          h12 = 5'h01;
        end else if (h12 == `RTC_FLIP_H12) begin
          h12 = `RTC_MAX_H12;
          carry = pm;
          pm = ~pm;
        end else begin
          h12 = 5'(binc({3'h0, h12}));
        end
        hr = {1'b0, 1'b1, pm, h12};
      end else if (hr[5:0] == `RTC_MAX_H24) begin
        hr = 8'h00;
        carry = 1'b1;
      end else begin
        hr = binc(hr);
      end
    end
    case (mo[4:0])
      `RTC_FEB: dim = mo[`RTC_CENTURY_BIT] ? `RTC_DIM_28 : `RTC_DIM_29;
      5'h04, 5'h06, 5'h09, 5'h11: dim = `RTC_DIM_30;
      default: dim = `RTC_DIM_31;
    endcase
    if (carry) begin
      dy = (dy[2:0] == `RTC_MAX_DAY) ? 8'h01 : dy + 8'h01;
      if (dt == dim) begin
        dt = 8'h01;
      end else begin
        dt = binc(dt);
        carry = 1'b0;
      end
    end
    if (carry) begin
      if (mo[4:0] == `RTC_MAX_MONTH) begin
        mo = {mo[7:5], 5'h01};
      end else begin
        mo = {mo[7:5], 5'(binc({3'h0, mo[4:0]}))};
        carry = 1'b0;
      end
    end
    if (carry) begin
      if (yr == `RTC_MAX_YEAR) begin
        yr = 8'h00;
        mo[`RTC_CENTURY_BIT] = ~mo[`RTC_CENTURY_BIT];
      end else begin
        yr = binc(yr);
      end
    end
    tif.nxt = {yr, mo, dt, dy, hr, mn, sec};
  end
endmodule // rtc_tod_step

// ===== src/rtc_i2c_tgt.sv
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_i2c_tgt #(
  parameter logic [6:0] DEV_ADDR = `RTC_I2C_ADDR // arbitrary bus address
) (
  input wire logic mclk_i, // system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic scl_i, // serial clock pin level
  input wire logic sda_i, // serial data pin level
  output logic sda_oe_o, // high while pulling the data line low
  rtc_bus_if.tgt bus // byte events toward the register map
);
  rtc_pkg::rtc_tgt_s q, d;
  logic scl_h, scl_r, scl_f, sda_h, sda_r, sda_f;

  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[1:0], scl_i};
    d.sda_s = {q.sda_s[1:0], sda_i};
    d.start = 1'b0;
    d.wr_stb = 1'b0;
    d.rd_stb = 1'b0;
    scl_h = q.scl_s[1] & q.scl_s[2];
    scl_r = q.scl_s[1] & ~q.scl_s[2];
    scl_f = ~q.scl_s[1] & q.scl_s[2];
    sda_h = q.sda_s[1];
    sda_r = q.sda_s[1] & ~q.sda_s[2];
    sda_f = ~q.sda_s[1] & q.sda_s[2];
    if (scl_h && sda_f) begin
      d.start = 1'b1;
      d.st = rtc_pkg::rtc_addr;
      d.bcnt = 4'h0;
      d.oe = 1'b0;
    end else if (scl_h && sda_r) begin
      d.st = rtc_pkg::rtc_idle;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        rtc_pkg::rtc_addr, rtc_pkg::rtc_wr: begin
          if (scl_r) begin
            d.sh = {q.sh[6:0], sda_h};
            d.bcnt = q.bcnt + 4'h1;
          end else if (scl_f && q.bcnt == 4'h8) begin
            if (!bus.access_ok) begin
              d.st = rtc_pkg::rtc_idle;
            end else if (q.st == rtc_pkg::rtc_wr) begin
              d.oe = 1'b1;
              d.wr_stb = 1'b1;
              d.st = rtc_pkg::rtc_wr_ack;
            end else if (q.sh[7:1] == DEV_ADDR) begin
              d.oe = 1'b1;
              d.rw = q.sh[0];
              d.first = 1'b1;
              d.st = rtc_pkg::rtc_addr_ack;
            end else begin
              d.st = rtc_pkg::rtc_idle;
            end
          end
        end
        rtc_pkg::rtc_wr_ack: begin
          if (scl_f) begin
            d.oe = 1'b0;
            d.bcnt = 4'h0;
            d.first = 1'b0;
            d.st = rtc_pkg::rtc_wr;
          end
        end
        rtc_pkg::rtc_addr_ack, rtc_pkg::rtc_rd_ack: begin
          if (scl_r) begin
            d.nack = sda_h & (q.st == rtc_pkg::rtc_rd_ack);
          end else if (scl_f) begin
            d.bcnt = 4'h0;
            d.oe = 1'b0;
            if (q.nack) begin
              d.st = rtc_pkg::rtc_idle;
            end else if (q.rw) begin
              d.sh = bus.rd_data;
              d.oe = ~bus.rd_data[7];
              d.rd_stb = 1'b1;
              d.st = rtc_pkg::rtc_rd;
            end else begin
              d.st = rtc_pkg::rtc_wr;
            end
          end
        end
        rtc_pkg::rtc_rd: begin
          if (scl_f) begin
            if (q.bcnt == 4'h7) begin
              d.oe = 1'b0;
              d.st = rtc_pkg::rtc_rd_ack;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.oe = ~q.sh[6];
              d.bcnt = q.bcnt + 4'h1;
            end
          end
        end
        default: d.st = rtc_pkg::rtc_idle;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{scl_s: 3'h7, sda_s: 3'h7, st: rtc_pkg::rtc_idle, default: '0};
    end else begin
      q <= d;
    end
  end

  assign sda_oe_o = q.oe;
  assign bus.start = q.start;
  assign bus.wr_stb = q.wr_stb;
  assign bus.rd_stb = q.rd_stb;
  assign bus.first = q.first;
  assign bus.wr_data = q.sh;
endmodule // rtc_i2c_tgt

// ===== src/rtc_core.sv
`timescale 1ns/1ns
`include "rtc_params.svh"
// Behaviour
// - short months and leap February roll correctly
// - hours bit six selects twelve-hour mode
// - bit five is meridiem or twenties digit
// - no register access below power-fail threshold; a read already past its address byte keeps returning bytes
// - run from backup below lower threshold
// - access blocked until recovery delay elapses
// - first power-up loads 01/01/00 day1 00:00:00
// - pointer increments per byte, wraps to zero
// - snapshot time on start or wrap
// - time fields held and counted in BCD
// - century bit toggles on year overflow
// - century clear means 29-day February
// - weekday advances at midnight, host sequential
// - seconds write resets the countdown chain
// - written byte transfers at its acknowledge
// - square wave rises half second after seconds
// - start, address, data until stop
// - wave/irq output is open drain
module rtc_core #(
  parameter int unsigned OSC_CYC = `RTC_OSC_HZ, // oscillator edges per second
  parameter int unsigned RECOV_CYC = `RTC_RECOVERY_CYC // access_recovery_delay in mclk cycles
) (
  input wire logic mclk_i, // system clock, 100 MHz
  input wire logic osc_clk_i, // crystal oscillator clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin level
  output logic sda_oe_o, // high while pulling data low
  input wire logic power_fail_i, // supply below power_fail_threshold
  input wire logic below_backup_i, // supply below backup_supply
  input wire logic wave_enable_i, // enables the 1 Hz square wave
  output logic wave_or_irq_oe_o, // high while pulling wave_or_irq_output low
  output logic on_backup_o, // device is running from backup_supply
  output logic access_ok_o // register access currently allowed
);
  localparam int unsigned HALF_CYC = OSC_CYC * `RTC_SQW_HIGH_MS / 1000;
  localparam rtc_pkg::rtc_osc_s OSC_RST = '{tod: `RTC_TOD_RST, default: '0};

  rtc_bus_if bif();
  rtc_step_if tif();
  rtc_pkg::rtc_core_s q, d;
  rtc_pkg::rtc_osc_s oq, od;

  rtc_i2c_tgt u_tgt (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .bus(bif.tgt)
  );

  rtc_tod_step u_step (
    .tif(tif.calc)
  );

  function automatic logic [4:0] ptr_inc(input logic [4:0] p);
    ptr_inc = (p == `RTC_REG_LAST) ? 5'h00 : p + 5'h01;
  endfunction

  // unused bits of time registers read back as zero
  function automatic logic [7:0] reg_mask(input logic [4:0] a);
    case (a)
      5'h00, 5'h01: reg_mask = `RTC_MASK_SEC;
      5'h02: reg_mask = `RTC_MASK_HOUR;
      5'h03: reg_mask = `RTC_MASK_DAY;
      5'h04: reg_mask = `RTC_MASK_DATE;
      5'h05: reg_mask = `RTC_MASK_MONTH;
      default: reg_mask = 8'hFF;
    endcase
  endfunction

  // ---- system clock side: bus, pointer, user buffers, power gating ----
  always_comb begin
    logic [4:0] np;
    np = ptr_inc(q.ptr);
    d = q;
    d.pf_s = {q.pf_s[0], power_fail_i};
    d.bk_s = {q.bk_s[0], below_backup_i};
    d.en_s = {q.en_s[0], wave_enable_i};
    d.wv_s = {q.wv_s[0], oq.wave};
    d.ack_s = {q.ack_s[1:0], oq.snap_ack};
    // switching needs the supply below both thresholds
    d.backup = q.pf_s[1] & q.bk_s[1];
    if (q.pf_s[1]) begin
      d.rec = 24'(RECOV_CYC);
    end else if (q.rec != 24'h0) begin
      d.rec = q.rec - 24'h1;
    end
    d.access = ~q.pf_s[1] & (q.rec == 24'h0);
    d.wave_oe = q.en_s[1] & ~q.wv_s[1];
    if (bif.start) begin
      d.snap_req = ~q.snap_req;
    end
    if (bif.wr_stb && q.access) begin
      if (bif.first) begin
        // a pointer past the map restarts at zero
        d.ptr = (bif.wr_data > 8'(`RTC_REG_LAST)) ? 5'h00 : bif.wr_data[4:0];
      end else begin
        d.mem[q.ptr] = bif.wr_data & reg_mask(q.ptr);
        if (q.ptr <= `RTC_REG_TOD_LAST) begin
          d.wr_idx = q.ptr[2:0];
          d.wr_val = bif.wr_data & reg_mask(q.ptr);
          d.wr_req = ~q.wr_req;
        end
        d.ptr = np;
        if (np == 5'h00) begin
          d.snap_req = ~q.snap_req;
        end
      end
    end
    if (bif.rd_stb) begin
      d.ptr = np;
      if (np == 5'h00) begin
        d.snap_req = ~q.snap_req;
      end
    end
    // hold is stable once the ack toggle has passed the synchroniser
    if (q.ack_s[2] != q.ack_s[1]) begin
      d.mem[6:0] = oq.hold;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bif.rd_data = q.mem[q.ptr];
  assign bif.access_ok = q.access;
  assign wave_or_irq_oe_o = q.wave_oe;
  assign on_backup_o = q.backup;
  assign access_ok_o = q.access;

  // ---- oscillator side: countdown chain and time counters ----
  assign tif.cur = oq.tod;

  always_comb begin
    od = oq;
    od.wr_s = {oq.wr_s[1:0], q.wr_req};
    od.snp_s = {oq.snp_s[1:0], q.snap_req};
    if (oq.div == 24'(OSC_CYC - 1)) begin
      od.div = 24'h0;
      od.tod = tif.nxt;
    end else begin
      od.div = oq.div + 24'h1;
    end
    // a host write wins over a tick landing in the same edge
    if (oq.wr_s[2] != oq.wr_s[1]) begin
      od.tod[q.wr_idx] = q.wr_val;
      if (q.wr_idx == 3'(`RTC_REG_SEC)) begin
        od.div = 24'h0;
      end
    end
    if (oq.snp_s[2] != oq.snp_s[1]) begin
      od.hold = oq.tod;
      od.snap_ack = ~oq.snap_ack;
    end
    od.wave = od.div >= 24'(HALF_CYC);
  end

  always_ff @(posedge osc_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oq <= OSC_RST;
    end else begin
      oq <= od;
    end
  end
endmodule // rtc_core

// ===== testbench/rtc_core_chk.sv
`timescale 1ns/1ns
module rtc_core_chk #(
  parameter int unsigned OSC_CYC = 32768, // osc edges per second
  parameter int unsigned RECOV_CYC = 25000 // recovery in mclk cycles
) (
  input wire logic mclk_i, // system clock
  input wire logic osc_clk_i, // crystal clock
  input wire logic rst_b_i, // reset, active low
  input wire logic scl_i, // serial clock
  input wire logic sda_i, // data line
  input wire logic sda_oe_o, // data pull-down
  input wire logic power_fail_i, // supply failing
  input wire logic below_backup_i, // below backup
  input wire logic wave_enable_i, // wave enable
  input wire logic wave_or_irq_oe_o, // wave pull-down
  input wire logic on_backup_o, // on backup
  input wire logic access_ok_o // access allowed
);
  // cycles since the supply came back; saturates so it never wraps
  int unsigned rec_q;
  int unsigned rec_d;
  always_comb begin
    rec_d = power_fail_i ? 0 : ((rec_q < RECOV_CYC + 8) ? rec_q + 1 : rec_q);
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rec_q <= RECOV_CYC;
    end else begin
      rec_q <= rec_d;
    end
  end
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_pf_hold;
    power_fail_i [*5];
  endsequence
  sequence s_pf_drop;
    s_pf_hold ##1 !power_fail_i;
  endsequence
  a_pf_blocks: assert property (s_pf_hold |-> !access_ok_o)
    else $error("access while supply failing");
  a_recov_live: assert property (rec_q == RECOV_CYC + 8 |-> access_ok_o)
    else $error("access not restored");
  a_recov_hold: assert property (s_pf_drop |=> !access_ok_o [*8])
    else $error("access right after recovery");
  // access lags a new failure by the input synchroniser, so skip those cycles
  a_recov_min: assert property (access_ok_o && !power_fail_i && !$past(power_fail_i)
      && !$past(power_fail_i, 2) |-> rec_q >= RECOV_CYC)
    else $error("access before recovery delay");
  a_backup_on: assert property ((power_fail_i && below_backup_i) [*5] |-> on_backup_o)
    else $error("backup not selected");
  a_backup_off: assert property (!power_fail_i [*5] |-> !on_backup_o)
    else $error("backup with good supply");
  a_wave_off: assert property (!wave_enable_i [*5] |-> !wave_or_irq_oe_o)
    else $error("wave pin driven when off");
  a_sda_stable: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data changed while clock high");
  a_ack_late: assert property ($rose(sda_oe_o) |-> !scl_i && $past(scl_i, 6))
    else $error("data drive late after clock fall");
endmodule // rtc_core_chk

bind rtc_core rtc_core_chk #(.OSC_CYC(OSC_CYC), .RECOV_CYC(RECOV_CYC)) u_chk (
  .mclk_i(mclk_i), .osc_clk_i(osc_clk_i), .rst_b_i(rst_b_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
  .power_fail_i(power_fail_i), .below_backup_i(below_backup_i),
  .wave_enable_i(wave_enable_i), .wave_or_irq_oe_o(wave_or_irq_oe_o),
  .on_backup_o(on_backup_o), .access_ok_o(access_ok_o)
);

// ===== testbench/rtc_i2c_host.sv
`timescale 1ns/1ns
module rtc_i2c_host #(
  parameter int Q = 5 // mclk cycles per quarter bit
) (
  input wire logic mclk_i, // system clock
  input wire logic sda_i, // resolved data line
  output logic scl_o, // serial clock, high between frames
  output logic sda_oe_o // high while pulling data low
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // data moves a quarter bit after the fall so the target sees clock first
  task automatic bit_x(input logic b, output logic r);
    sda_oe_o = !b;
    w(Q);
    scl_o = 1'b1;
    w(Q);
    r = sda_i;
    w(Q);
    scl_o = 1'b0;
    w(Q);
  endtask
  task automatic start_c();
    sda_oe_o = 1'b0;
    w(Q);
    scl_o = 1'b1;
    w(Q);
    sda_oe_o = 1'b1;
    w(Q);
    scl_o = 1'b0;
    w(Q);
  endtask
  task automatic stop_c();
    sda_oe_o = 1'b1;
    w(Q);
    scl_o = 1'b1;
    w(Q);
    sda_oe_o = 1'b0;
    w(Q);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(!more, r);
  endtask
endmodule // rtc_i2c_host

// ===== testbench/rtc_timekeeping_core_tb.sv
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_timekeeping_core_tb;
  localparam int unsigned OSC = 1024;
  localparam int unsigned REC = 20;
  logic mclk_i;
  logic osc_clk_i;
  logic rst_b_i;
  logic power_fail_i;
  logic below_backup_i;
  logic wave_enable_i;
  logic scl;
  logic h_oe;
  logic d_oe;
  logic wave_oe;
  logic on_bk;
  logic acc;
  int errors;
  int check_count;
  wire sda = ~(h_oe | d_oe);
  rtc_core #(.OSC_CYC(OSC), .RECOV_CYC(REC)) dut (
    .mclk_i(mclk_i), .osc_clk_i(osc_clk_i), .rst_b_i(rst_b_i),
    .scl_i(scl), .sda_i(sda), .sda_oe_o(d_oe),
    .power_fail_i(power_fail_i), .below_backup_i(below_backup_i),
    .wave_enable_i(wave_enable_i), .wave_or_irq_oe_o(wave_oe),
    .on_backup_o(on_bk), .access_ok_o(acc)
  );
  rtc_i2c_host host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    osc_clk_i = 1'b0;
    #7;
    forever #15 osc_clk_i = ~osc_clk_i;
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_tod(input rtc_pkg::rtc_tod_t g, input rtc_pkg::rtc_tod_t e, input int n);
    for (int i = 0; i < n; i++) begin
      chk8(g[i], e[i]);
    end
  endtask
  task automatic addr(input logic [6:0] da, input logic rd, input logic ea);
    logic a;
    host.start_c();
    host.wr_byte({da, rd}, a);
    chk8({7'h00, a}, {7'h00, ea});
  endtask
  task automatic wr_regs(input logic [4:0] p, input int n, input rtc_pkg::rtc_tod_t v);
    logic a;
    addr(`RTC_I2C_ADDR, 1'b0, 1'b1);
    host.wr_byte({3'h0, p}, a);
    for (int i = 0; i < n; i++) begin
      host.wr_byte(v[i], a);
      chk8({7'h00, a}, 8'h01);
    end
    host.stop_c();
  endtask
  task automatic rd_regs(input logic [4:0] p, input int n, output rtc_pkg::rtc_tod_t v);
    logic a;
    addr(`RTC_I2C_ADDR, 1'b0, 1'b1);
    host.wr_byte({3'h0, p}, a);
    addr(`RTC_I2C_ADDR, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      host.rd_byte(i < n - 1, v[i]);
    end
    host.stop_c();
  endtask
  task automatic t_reset();
    rtc_pkg::rtc_tod_t g;
    rd_regs(5'h00, 7, g);
    chk_tod(g, 56'h00_01_01_01_00_00_00, 7);
  endtask
  task automatic t_wrap();
    rtc_pkg::rtc_tod_t g;
    wr_regs(5'h0F, 3, 56'h30_C3_3C);
    rd_regs(5'h0F, 3, g);
    chk_tod(g, 56'h30_C3_3C, 3);
    // a pointer byte beyond the map restarts at the seconds register
    rd_regs(5'h1F, 1, g);
    chk8(g[0], 8'h30);
  endtask
  task automatic t_power();
    power_fail_i = 1'b1;
    w(6);
    chk8({6'h00, on_bk, acc}, 8'h00);
    addr(`RTC_I2C_ADDR, 1'b0, 1'b0);
    host.stop_c();
    below_backup_i = 1'b1;
    w(6);
    chk8({7'h00, on_bk}, 8'h01);
    power_fail_i = 1'b0;
    below_backup_i = 1'b0;
    w(REC - 4);
    chk8({6'h00, on_bk, acc}, 8'h00);
    w(12);
    chk8({7'h00, acc}, 8'h01);
    addr(7'h52, 1'b0, 1'b0);
    host.stop_c();
  endtask
  // a seconds write restarts the countdown, so the wave edge is timed from it
  task automatic t_wave();
    wave_enable_i = 1'b1;
    wr_regs(5'h00, 1, 56'h00);
    w(1300);
    chk8({7'h00, wave_oe}, 8'h01);
    w(400);
    chk8({7'h00, wave_oe}, 8'h00);
    wave_enable_i = 1'b0;
  endtask
  task automatic t_roll();
    rtc_pkg::rtc_tod_t tin [8];
    rtc_pkg::rtc_tod_t tex [8];
    rtc_pkg::rtc_tod_t g;
    tin = '{56'h99_02_28_07_23_59_59, 56'h99_12_31_03_23_59_59, 56'h05_04_30_01_23_59_59,
      56'h01_82_28_02_23_59_59, 56'h01_01_31_05_71_59_59, 56'h01_01_15_05_51_59_59,
      56'h01_01_15_05_52_59_59, 56'h01_01_15_05_19_59_59};
    tex = '{56'h99_02_29_01_00_00_00, 56'h00_81_01_04_00_00_00, 56'h05_05_01_02_00_00_00,
      56'h01_83_01_03_00_00_00, 56'h01_02_01_06_52_00_00, 56'h01_01_15_05_72_00_00,
      56'h01_01_15_05_41_00_00, 56'h01_01_15_05_20_00_00};
    for (int k = 0; k < 8; k++) begin
      wr_regs(5'h00, 7, tin[k]);
      w(2200);
      rd_regs(5'h00, 7, g);
      chk_tod(g, tex[k], 7);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    errors = 0;
    check_count = 0;
    rst_b_i = 1'b0;
    power_fail_i = 1'b0;
    below_backup_i = 1'b0;
    wave_enable_i = 1'b0;
    w(4);
    rst_b_i = 1'b1;
    w(12);
    t_reset();
    t_wrap();
    t_power();
    t_wave();
    t_roll();
    finish_test();
  end
  initial begin
    w(90000);
    errors++;
    finish_test();
  end
endmodule // rtc_timekeeping_core_tb
